// file: hdl/feec_ctrl.sv
// flash eeprom emulation controller: word cache, page swap sequencer, program flash access
`timescale 1ns/1ps
// Summary of operation
// R1: four byte cache forms the flash word
// R2: byte mode merges byte into flash word
// R3: byte port and direct cache bytes usable
// R4: erase works on whole 1K pages
// R5: each emulated page backed by page pair
// R6: last four page bytes hold status
// R7: erase swap, copy before, write, copy after
// R8: status updated last, previous page stays valid
// R9: each emulated 1K uses own pair
// R10: continuous mode writes swap page directly
// R11: final normal write copies and updates status
// R12: software erases program page before writing
// R13: program writes whole words, ignore bits 1:0
// R14: address is byte address or page address
// R15: program writes issued singly, no continuous mode
// R16: control selects read, program or erase
// R17: software sets configuration before use
// R18: arm then strobe within four cycles
// R19: mode field encodes erase, program, byte, word
// R20: read data valid two cycles after strobe
// R21: cpu stalled until emulated write completes
// R22: requests ignored while an operation runs
module feec_ctrl (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // cpu control
    input wire logic [feec_pkg::ADDR_W-1:0] target_address_i,
    input wire logic [3:0] operation_mode_field_i,
    input wire logic write_arm_i,
    input wire logic write_strobe_i,
    input wire logic read_strobe_i,
    input wire logic continuous_write_enable_i,
    input wire logic [1:0] emu_pairs_i,
    input wire logic pre_target_region_i,
    input wire logic post_target_region_i,
    input wire logic [feec_pkg::ADDR_W-1:0] emu_base_i,
    // cpu data
    input wire logic byte_data_we_i,
    input wire logic [7:0] byte_data_i,
    input wire logic [3:0] cache_byte_we_i,
    input wire logic [31:0] cache_wdata_i,
    output logic [7:0] byte_data_o,
    output logic [31:0] word_cache_bytes_o,
    output logic cpu_stall_o,
    output logic busy_o,
    // flash array
    output logic flash_rd_o,
    output logic flash_wr_o,
    output logic flash_erase_o,
    output logic [feec_pkg::ADDR_W-3:0] flash_word_addr_o,
    output logic [31:0] flash_wdata_o,
    input wire logic [31:0] flash_rdata_i,
    input wire logic flash_done_i
);
    import feec_pkg::*;

    feec_state_e state_reg, state_next;
    logic [31:0] cache_reg, cache_next;
    logic [2:0] arm_cnt_reg, arm_cnt_next;
    logic [1:0] lat_reg, lat_next;
    logic [7:0] idx_reg, idx_next;
    logic [3:0] cur_sel_reg, cur_sel_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic rd_reg, rd_next, wr_reg, wr_next, er_reg, er_next;
    logic [ADDR_W-3:0] fa_reg, fa_next;
    logic [31:0] fd_reg, fd_next;
    logic [7:0] byte_out_reg, byte_out_next;

    // base of page within pair; pair p uses pages base+2p and base+2p+1
    function automatic logic [ADDR_W-3:0] page_word(input logic [ADDR_W-1:0] base,
                                                    input logic [1:0] pair,
                                                    input logic half,
                                                    input logic [7:0] idx);
        logic [ADDR_W-PAGE_BIT-1:0] pg;
        pg = base[ADDR_W-1:PAGE_BIT] + {pair, half}; // R9
        return {pg, idx};
    endfunction

    // replace one byte lane of a word
    function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] lane,
                                             input logic [7:0] b);
        logic [31:0] r;
        r = w;
        r[lane*8 +: 8] = b;
        return r;
    endfunction

    logic arm_ok, mode_erase, mode_prog, mode_ee_byte, mode_ee_word;
    logic [1:0] pair;
    logic [7:0] tgt_idx;
    logic cp_region, cur_b;

    // pair of the latched request, clamped like the live decode
    function automatic logic [1:0] pair_reg_w();
        return (addr_reg[11:10] > emu_pairs_i) ? emu_pairs_i : addr_reg[11:10];
    endfunction
    assign mode_erase = (operation_mode_field_i & MODE_ERASE_MASK) == MODE_ERASE_VAL; // R19
    assign mode_prog = (operation_mode_field_i & MODE_ERASE_MASK) == MODE_PROG_VAL;
    assign mode_ee_byte = operation_mode_field_i[3:1] == MODE_EE_BYTE;
    assign mode_ee_word = operation_mode_field_i[3:1] == MODE_EE_WORD;
    assign arm_ok = arm_cnt_reg != 3'h0; // R18
    assign pair = (target_address_i[11:10] > emu_pairs_i) ? emu_pairs_i : target_address_i[11:10];
    assign tgt_idx = addr_reg[9:2];
    // a process, not an assign, so the latched address inside the call is tracked
    always_comb cur_b = cur_sel_reg[pair_reg_w()];
    // region of the swap copy: before or after the target word
    assign cp_region = (idx_reg < tgt_idx) ? pre_target_region_i : post_target_region_i;

    // next-state logic of the sequencer
    always_comb begin
        state_next = state_reg;
        cache_next = cache_reg;
        arm_cnt_next = (arm_cnt_reg != 3'h0) ? arm_cnt_reg - 3'h1 : 3'h0;
        lat_next = lat_reg;
        idx_next = idx_reg;
        cur_sel_next = cur_sel_reg;
        addr_next = addr_reg;
        rd_next = 1'b0;
        wr_next = 1'b0;
        er_next = 1'b0;
        fa_next = fa_reg;
        fd_next = fd_reg;
        byte_out_next = byte_out_reg;
        if (write_arm_i && !write_strobe_i) begin
            arm_cnt_next = ARM_WINDOW; // R18
        end
        // cpu access to cache; hardware fill paths below take priority
        if (byte_data_we_i) begin
            cache_next = put_byte(cache_next, target_address_i[1:0], byte_data_i); // R3
        end
        for (int i = 0; i < 4; i++) begin
            if (cache_byte_we_i[i]) begin
                cache_next[i*8 +: 8] = cache_wdata_i[i*8 +: 8]; // R3
            end
        end
        byte_out_next = cache_next[target_address_i[1:0]*8 +: 8];
        case (state_reg)
            FEEC_IDLE: begin
                addr_next = target_address_i; // R14
                if (read_strobe_i && (mode_ee_byte || mode_ee_word)) begin
                    fa_next = page_word(emu_base_i, pair, cur_sel_reg[pair],
                                        target_address_i[9:2]);
                    rd_next = 1'b1;
                    lat_next = 2'(READ_LAT - 1);
                    state_next = FEEC_RD_WAIT;
                end else if (write_strobe_i && arm_ok) begin // R16
                    arm_cnt_next = 3'h0;
                    if (mode_erase) begin
                        fa_next = {target_address_i[ADDR_W-1:PAGE_BIT], 8'h00}; // R4
                        er_next = 1'b1;
                        state_next = FEEC_PF_OP;
                    end else if (mode_prog) begin
                        fa_next = target_address_i[ADDR_W-1:2]; // R13
                        fd_next = cache_reg; // R1
                        wr_next = 1'b1; // R15
                        state_next = FEEC_PF_OP;
                    end else if ((mode_ee_byte || mode_ee_word)
                                 && target_address_i[9:2] != STATUS_WORD_IDX) begin // R6
                        fa_next = page_word(emu_base_i, pair, cur_sel_reg[pair],
                                            target_address_i[9:2]);
                        rd_next = mode_ee_byte;
                        state_next = mode_ee_byte ? FEEC_MERGE_RD : FEEC_DIRECT_WR;
                    end
                end
            end
            FEEC_RD_WAIT: begin
                if (lat_reg == 2'h0) begin
                    cache_next = flash_rdata_i; // R20
                    byte_out_next = flash_rdata_i[addr_reg[1:0]*8 +: 8];
                    state_next = FEEC_IDLE;
                end else begin
                    lat_next = lat_reg - 2'h1;
                end
            end
            FEEC_PF_OP: begin
                if (flash_done_i) begin
                    state_next = FEEC_IDLE;
                end
            end
            FEEC_MERGE_RD: begin
                if (flash_done_i) begin
                    cache_next = put_byte(flash_rdata_i, addr_reg[1:0],
                                          cache_reg[addr_reg[1:0]*8 +: 8]); // R2
                    state_next = FEEC_DIRECT_WR;
                end
            end
            FEEC_DIRECT_WR: begin
                if (continuous_write_enable_i) begin
                    fa_next = page_word(emu_base_i, pair_reg_w(), !cur_b, tgt_idx);
                    fd_next = cache_reg;
                    wr_next = 1'b1; // R10
                    state_next = FEEC_PF_OP;
                end else begin
                    fa_next = page_word(emu_base_i, pair_reg_w(), !cur_b, 8'h00);
                    er_next = 1'b1; // R7
                    idx_next = 8'h00;
                    state_next = FEEC_SW_ERASE; // R11
                end
            end
            FEEC_SW_ERASE: begin
                if (flash_done_i) begin
                    state_next = FEEC_CP_RD;
                    idx_next = 8'h00;
                end
            end
            FEEC_CP_RD: begin
                if (idx_reg == STATUS_WORD_IDX) begin
                    fa_next = page_word(emu_base_i, pair_reg_w(), !cur_b, STATUS_WORD_IDX);
                    fd_next = PAGE_VALID_WORD;
                    wr_next = 1'b1; // R8
                    state_next = FEEC_STATUS_NEW;
                end else if (idx_reg == tgt_idx) begin
                    fa_next = page_word(emu_base_i, pair_reg_w(), !cur_b, idx_reg);
                    fd_next = cache_reg; // R7
                    wr_next = 1'b1;
                    state_next = FEEC_CP_WR;
                end else if (cp_region) begin
                    fa_next = page_word(emu_base_i, pair_reg_w(), cur_b, idx_reg);
                    rd_next = 1'b1;
                    state_next = FEEC_STATUS_OLD;
                end else begin
                    idx_next = idx_reg + 8'h01;
                end
            end
            FEEC_STATUS_OLD: begin
                // copied word read back from the current page
                if (flash_done_i) begin
                    fa_next = page_word(emu_base_i, pair_reg_w(), !cur_b, idx_reg);
                    fd_next = flash_rdata_i;
                    wr_next = 1'b1; // R7
                    state_next = FEEC_CP_WR;
                end
            end
            FEEC_CP_WR: begin
                if (flash_done_i) begin
                    idx_next = idx_reg + 8'h01;
                    state_next = FEEC_CP_RD;
                end
            end
            FEEC_STATUS_NEW: begin
                if (flash_done_i) begin
                    cur_sel_next[pair_reg_w()] = !cur_b; // R5
                    state_next = FEEC_IDLE;
                end
            end
            default: state_next = FEEC_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg <= FEEC_IDLE;
            cache_reg <= 32'h00000000;
            arm_cnt_reg <= 3'h0;
            lat_reg <= 2'h0;
            idx_reg <= 8'h00;
            cur_sel_reg <= 4'h0;
            addr_reg <= '0;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            er_reg <= 1'b0;
            fa_reg <= '0;
            fd_reg <= 32'h00000000;
            byte_out_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            cache_reg <= cache_next;
            arm_cnt_reg <= arm_cnt_next;
            lat_reg <= lat_next;
            idx_reg <= idx_next;
            cur_sel_reg <= cur_sel_next;
            addr_reg <= addr_next;
            rd_reg <= rd_next;
            wr_reg <= wr_next;
            er_reg <= er_next;
            fa_reg <= fa_next;
            fd_reg <= fd_next;
            byte_out_reg <= byte_out_next;
        end
    end

    // outputs; stall covers the whole emulated write including its erase
    assign busy_o = state_reg != FEEC_IDLE; // R22
    assign cpu_stall_o = busy_o && state_reg != FEEC_RD_WAIT; // R21
    assign byte_data_o = byte_out_reg;
    assign word_cache_bytes_o = cache_reg;
    assign flash_rd_o = rd_reg;
    assign flash_wr_o = wr_reg;
    assign flash_erase_o = er_reg;
    assign flash_word_addr_o = fa_reg;
    assign flash_wdata_o = fd_reg;
endmodule // feec_ctrl

// file: hdl/feec_pkg.sv
// package: constants, modes and states of the flash eeprom emulation controller
package feec_pkg;
    localparam int ADDR_W = 15;
    localparam int PAGE_BYTES = 1024;
    localparam int PAGE_BIT = 10;
    localparam int WORDS_PER_PAGE = 256;
    localparam logic [7:0] STATUS_WORD_IDX = 8'hFF;
    localparam logic [31:0] PAGE_VALID_WORD = 32'hA55A0000;
    localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
    localparam int ARM_WINDOW_CYCLES = 4;
    localparam logic [2:0] ARM_WINDOW = 3'h4;
    localparam int READ_LAT = 2;
    localparam logic [3:0] MODE_ERASE_MASK = 4'hB;
    localparam logic [3:0] MODE_ERASE_VAL = 4'h9;
    localparam logic [3:0] MODE_PROG_VAL = 4'hA;
    localparam logic [2:0] MODE_EE_BYTE = 3'h0;
    localparam logic [2:0] MODE_EE_WORD = 3'h2;
    localparam logic [1:0] EMU_PAIRS_MAX = 2'h3;

    typedef enum logic [3:0] {
        FEEC_IDLE = 4'h0,
        FEEC_RD_WAIT = 4'h1,
        FEEC_PF_OP = 4'h2,
        FEEC_SW_ERASE = 4'h3,
        FEEC_CP_RD = 4'h4,
        FEEC_CP_WR = 4'h5,
        FEEC_STATUS_OLD = 4'h6,
        FEEC_STATUS_NEW = 4'h7,
        FEEC_MERGE_RD = 4'h8,
        FEEC_DIRECT_WR = 4'h9
    } feec_state_e;
endpackage

// file: bench/feec_flash_model.sv
// flash array model: word memory answering read, program and page erase strobes
`timescale 1ns/1ps
module feec_flash_model #(parameter int LAT = 3) (
    // controller side
    input wire logic sys_clk_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic erase_i,
    input wire logic [feec_pkg::ADDR_W-3:0] addr_i,
    input wire logic [31:0] wdata_i,
    // answer
    output logic [31:0] rdata_o = 32'h0,
    output logic done_o = 1'b0
);
    import feec_pkg::*;
    logic [31:0] mem [0:8191];
    logic [31:0] last = 32'h0;
    logic [12:0] pend_addr;
    logic [31:0] pend_data;
    logic pend_erase;
    int cnt = 0;
    // array starts cleared so erase and copy effects can be told apart
    initial begin
        foreach (mem[i]) begin
            mem[i] = 32'h0;
        end
    end
    // reads answer next cycle; program and erase take LAT cycles
    always @(posedge sys_clk_i) begin
        done_o <= rd_i;
        rdata_o <= rd_i ? mem[addr_i] : ~last; // idle bus never shows a stale word
        if (rd_i)
            last <= mem[addr_i];
        if (cnt > 0)
            cnt <= cnt - 1;
        if (cnt == 1) begin
            done_o <= 1'b1;
            if (pend_erase) begin
                for (int i = 0; i < WORDS_PER_PAGE; i++) begin
                    mem[{pend_addr[12:8], i[7:0]}] <= ERASED_WORD;
                end
            end else begin
                mem[pend_addr] <= mem[pend_addr] & pend_data;
            end
        end
        if (wr_i || erase_i) begin
            cnt <= LAT;
            pend_erase <= erase_i;
            pend_addr <= addr_i;
            pend_data <= wdata_i;
        end
    end
endmodule // feec_flash_model

// file: bench/feec_ctrl_assertions.sv
// checker: port timing and sequencing properties of the emulation controller
`timescale 1ns/1ps
module feec_ctrl_assertions
    import feec_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // requests
    input wire logic [feec_pkg::ADDR_W-1:0] target_address_i,
    input wire logic [3:0] operation_mode_field_i,
    input wire logic write_arm_i,
    input wire logic write_strobe_i,
    input wire logic read_strobe_i,
    input wire logic continuous_write_enable_i,
    // results
    input wire logic [31:0] word_cache_bytes_o,
    input wire logic cpu_stall_o,
    input wire logic busy_o,
    input wire logic flash_rd_o,
    input wire logic flash_wr_o,
    input wire logic flash_erase_o,
    input wire logic [feec_pkg::ADDR_W-3:0] flash_word_addr_o,
    input wire logic [31:0] flash_wdata_o
);
    logic [3:0] arm_age_reg, arm_age_next;
    logic erased_reg, erased_next, cont_seen_reg, cont_seen_next;
    // arm age saturates so a stale arm never looks fresh
    always_comb begin
        arm_age_next = (arm_age_reg == 4'hF) ? 4'hF : arm_age_reg + 4'h1;
        if (write_arm_i && !write_strobe_i)
            arm_age_next = 4'h0;
        erased_next = busy_o && (erased_reg || flash_erase_o);
        cont_seen_next = continuous_write_enable_i || (busy_o && cont_seen_reg);
    end
    always_ff @(posedge sys_clk_i) begin
        arm_age_reg <= rst_i ? 4'hF : arm_age_next;
        erased_reg <= rst_i ? 1'b0 : erased_next;
        cont_seen_reg <= rst_i ? 1'b0 : cont_seen_next;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    AST_ARM_START: assert property ((!busy_o && write_strobe_i && arm_age_reg <= 4'h3 &&
        (operation_mode_field_i & MODE_ERASE_MASK) == MODE_ERASE_VAL) |=> flash_erase_o && busy_o)
        else $error("armed erase did not start");
    AST_ARM_REFUSE: assert property ((!busy_o && write_strobe_i && arm_age_reg >= 4'h4)
        |=> !busy_o) else $error("strobe without fresh arm started");
    AST_READ_LAT: assert property ((!busy_o && read_strobe_i && !operation_mode_field_i[3])
        |=> !cpu_stall_o ##1 !cpu_stall_o ##[0:1] !busy_o) else $error("read took too long");
    AST_PROG_WORD: assert property ((flash_wr_o && operation_mode_field_i[3]) |->
        flash_word_addr_o == target_address_i[ADDR_W-1:2] && flash_wdata_o == word_cache_bytes_o)
        else $error("program word address or data wrong");
    AST_ERASE_PAGE: assert property ((flash_erase_o && operation_mode_field_i[3]) |->
        flash_word_addr_o == {target_address_i[ADDR_W-1:PAGE_BIT], 8'h00})
        else $error("erase page address wrong");
    AST_SWAP_FIRST: assert property ((flash_wr_o && !operation_mode_field_i[3] &&
        !cont_seen_reg) |-> erased_reg) else $error("swap page written before erase");
    AST_CONT_NO_COPY: assert property ((busy_o && cpu_stall_o && continuous_write_enable_i &&
        operation_mode_field_i[3:1] == MODE_EE_WORD) |-> !flash_rd_o) else $error("copy in cont");
    AST_STALL: assert property ((flash_erase_o || flash_wr_o) |-> cpu_stall_o && busy_o)
        else $error("flash busy without stall");
endmodule // feec_ctrl_assertions
bind feec_ctrl feec_ctrl_assertions feec_ctrl_assertions_inst (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .target_address_i(target_address_i), .write_arm_i(write_arm_i),
    .operation_mode_field_i(operation_mode_field_i), .write_strobe_i(write_strobe_i),
    .read_strobe_i(read_strobe_i), .continuous_write_enable_i(continuous_write_enable_i),
    .word_cache_bytes_o(word_cache_bytes_o), .cpu_stall_o(cpu_stall_o), .busy_o(busy_o),
    .flash_rd_o(flash_rd_o), .flash_wr_o(flash_wr_o), .flash_erase_o(flash_erase_o),
    .flash_word_addr_o(flash_word_addr_o), .flash_wdata_o(flash_wdata_o));

// file: bench/tb_feec_ctrl.sv
// testbench: cache, program flash and emulated eeprom flows against a flash model
`timescale 1ns/1ps
module tb_feec_ctrl;
    import feec_pkg::*;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, arm = 1'b0, wstb = 1'b0, rstb = 1'b0, cont = 1'b0;
    logic pre = 1'b1, bwe = 1'b0, busy, stall, went;
    logic [ADDR_W-1:0] addr = 15'h0000;
    logic [3:0] mode = 4'h0, cwe = 4'h0;
    logic [7:0] bdat = 8'h00, bdo;
    logic [31:0] cwd = 32'h0, cache, frdata, fwdata;
    logic frd, fwr, fer, fdone;
    logic [ADDR_W-3:0] fadr;
    int err_count = 0;
    int checked = 0;
    always #12.5 sys_clk_i = ~sys_clk_i;
    feec_ctrl feec_ctrl_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .target_address_i(addr),
        .operation_mode_field_i(mode), .write_arm_i(arm), .write_strobe_i(wstb),
        .read_strobe_i(rstb), .continuous_write_enable_i(cont), .emu_pairs_i(2'h1),
        .pre_target_region_i(pre), .post_target_region_i(1'b1), .emu_base_i(15'h6000),
        .byte_data_we_i(bwe), .byte_data_i(bdat), .cache_byte_we_i(cwe), .cache_wdata_i(cwd),
        .byte_data_o(bdo), .word_cache_bytes_o(cache), .cpu_stall_o(stall), .busy_o(busy),
        .flash_rd_o(frd), .flash_wr_o(fwr), .flash_erase_o(fer), .flash_word_addr_o(fadr),
        .flash_wdata_o(fwdata), .flash_rdata_i(frdata), .flash_done_i(fdone));
    feec_flash_model #(.LAT(3)) feec_flash_model_inst (.sys_clk_i(sys_clk_i), .rd_i(frd),
        .wr_i(fwr), .erase_i(fer), .addr_i(fadr), .wdata_i(fwdata), .rdata_o(frdata),
        .done_o(fdone));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    function automatic logic [31:0] fm(input logic [12:0] w);
        return feec_flash_model_inst.mem[w];
    endfunction
    // arm, strobe gap+1 edges later, then wait for idle; went records acceptance
    task automatic launch(input logic [3:0] m, input logic [ADDR_W-1:0] a, input int gap);
        int n;
        n = 0;
        mode <= m;
        addr <= a;
        arm <= 1'b1;
        @(posedge sys_clk_i);
        arm <= 1'b0;
        cyc(gap);
        wstb <= 1'b1;
        @(posedge sys_clk_i);
        wstb <= 1'b0;
        @(negedge sys_clk_i);
        went = busy;
        while (busy !== 1'b0 && n < 6000) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk("busy", 32'h0, {31'h0, busy});
        @(posedge sys_clk_i);
    endtask
    // the cache is looked at two edges after the strobe edge, no earlier
    task automatic rd(input logic [3:0] m, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        mode <= m;
        addr <= a;
        rstb <= 1'b1;
        @(posedge sys_clk_i);
        rstb <= 1'b0;
        @(negedge sys_clk_i);
        chk("read stall", 32'h0, {31'h0, stall});
        chk("read busy", 32'h1, {31'h0, busy});
        cyc(2);
        @(negedge sys_clk_i);
        chk("read word", exp, cache);
        cyc(2);
    endtask
    task automatic put(input logic [31:0] d);
        cwe <= 4'hF;
        cwd <= d;
        @(posedge sys_clk_i);
        cwe <= 4'h0;
        cyc(1);
    endtask
    task automatic final_report();
        if (err_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        cyc(5);
        rst_i <= 1'b0;
        @(negedge sys_clk_i);
        chk("cache at reset", 32'h0, cache);
        @(posedge sys_clk_i);
        put(32'h11223344);
        addr <= 15'h0002;
        cyc(2);
        @(negedge sys_clk_i);
        chk("cache", 32'h11223344, cache);
        chk("byte lane", 32'h22, {24'h0, bdo});
        @(posedge sys_clk_i);
        launch(4'h9, 15'h1404, 0);
        chk("erased", ERASED_WORD, fm(13'h05FF));
        launch(4'hE, 15'h1407, 0);
        chk("programmed", 32'h11223344, fm(13'h0501));
        chk("untouched", ERASED_WORD, fm(13'h0500));
        launch(4'hD, 15'h1BFC, 0);
        launch(4'hA, 15'h1800, 0);
        chk("programmed 2", 32'h11223344, fm(13'h0600));
        launch(4'h9, 15'h0000, 8);
        chk("stale arm", 32'h0, {31'h0, went});
        put(32'hCAFE0001);
        launch(4'h4, 15'h0004, 0);
        chk("target", 32'hCAFE0001, fm(13'h1901));
        chk("pre copy", 32'h0, fm(13'h1900));
        chk("status", PAGE_VALID_WORD, fm(13'h19FF));
        put(32'h0);
        rd(4'h5, 15'h0004, 32'hCAFE0001);
        bdat <= 8'hEE;
        bwe <= 1'b1;
        addr <= 15'h0005;
        @(posedge sys_clk_i);
        bwe <= 1'b0;
        launch(4'h1, 15'h0005, 0);
        rd(4'h0, 15'h0004, 32'hCAFEEE01);
        pre <= 1'b0;
        launch(4'h5, 15'h0008, 0);
        chk("pre skipped", ERASED_WORD, fm(13'h1900));
        chk("post copy", 32'h0, fm(13'h1903));
        launch(4'h4, 15'h03FC, 0);
        chk("status refused", 32'h0, {31'h0, went});
        launch(4'h4, 15'h0404, 0);
        chk("second pair", 32'hCAFEEE01, fm(13'h1B01));
        // continuous writes land unerased, so software clears the swap page first
        launch(4'h9, 15'h6800, 0);
        cont <= 1'b1;
        launch(4'h4, 15'h0410, 0);
        chk("direct", 32'hCAFEEE01, fm(13'h1A04));
        chk("no status in cont", ERASED_WORD, fm(13'h1AFF));
        cont <= 1'b0;
        launch(4'h4, 15'h0414, 0);
        chk("final status", PAGE_VALID_WORD, fm(13'h1AFF));
        chk("final target", 32'hCAFEEE01, fm(13'h1A05));
        final_report();
    end
    // watchdog well beyond the longest expected run
    initial begin
        cyc(60000);
        err_count++;
        final_report();
    end
endmodule // tb_feec_ctrl
